// ==== src/mcsc_defs.svh ====
// Purpose: offsets, field positions, reset values and counts of the main clock switchover control
// Assumes: byte addresses on a 32-bit Avalon-MM slave, one register per aligned word
// Notes: definitions only
`ifndef MCSC_DEFS_SVH
`define MCSC_DEFS_SVH

`define MCSC_OFS_SYSCLK_CTRL 4'h0
`define MCSC_OFS_OSC_RUN 4'h4
`define MCSC_OFS_OP_MODE 4'h8

`define MCSC_BIT_SELECT 4
`define MCSC_BIT_STATUS 5
`define MCSC_BIT_IH_HALT 0
`define MCSC_BIT_MX_HALT 7
`define MCSC_BIT_CRYSTAL 6
`define MCSC_BIT_EXT_IN 7

`define MCSC_RST_IH_HALT 1'h0
`define MCSC_RST_MX_HALT 1'h1
`define MCSC_BYTE_ACCESS 4'h1

`define MCSC_MIN_SWITCH_CYCLES 2
`define MCSC_F_IH_KHZ 8000
`define MCSC_F_MX_KHZ 10000

`endif

// ==== src/mcsc_pkg.sv ====
// Purpose: types of the main clock switchover control
// Assumes: nothing
// Notes: constants live in mcsc_defs.svh
package mcsc_pkg;

	typedef enum logic [0:0] {
		MCSC_RUN = 1'b0,
		MCSC_WAIT = 1'b1
	} mcsc_state_t;

	typedef struct packed {
		logic read;
		logic write;
		logic [3:0] address;
		logic [3:0] byteenable;
		logic [31:0] writedata;
	} mcsc_req_t;

	typedef struct packed {
		logic crystal;
		logic ext_in;
		logic ih_halt;
		logic mx_halt;
	} mcsc_osc_t;

endpackage

// ==== src/mcsc_sync.sv ====
// Purpose: two-flop synchroniser of a clock pin with rising edge pulse
// Assumes: pin toggles slower than half of CLK
// Notes: the first stage feeds only the second
`timescale 1ns/1ns
`default_nettype none
module mcsc_sync (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// pin side
	input wire logic d,
	// logic side
	output logic rise
);
	logic s1;
	logic s2;
	logic s3;

	always_ff @(posedge clk) begin
		if (rst) begin
			s1 <= 1'b0;
			s2 <= 1'b0;
			s3 <= 1'b0;
		end else begin
			s1 <= d;
			s2 <= s1;
			s3 <= s2;
		end
	end

	assign rise = s2 & ~s3;
endmodule // mcsc_sync
`default_nettype wire

// ==== src/mcsc_top.sv ====
// Purpose: main system clock source selection with delayed switchover
// Assumes: oscillator clocks arrive as pins sampled by CLK; an outside glitch-free mux obeys SRC
// Notes: register access over Avalon-MM with waitrequest
// What this block does
// - Select bit 4 of system clock control picks internal oscillator (0) or system clock (1).
// - After rewriting select, keep the old source a few cycles before moving.
// - Read-only bit 5 reports which source really drives the main clock.
// - Peripheral clock source moves together with the CPU clock source.
// - Delay is 2 cycles to a not slower source, else twice the frequency ratio.
// - Delay counts cycles of the source active before the switch.
// - Fractional cycle counts of the ratio are truncated.
// - Internal oscillator halt may be set only while status reads 1.
// - System clock halt may be set only while status reads 0.
// - Clock operation mode accepts one byte write after reset, later writes ignored.
`include "mcsc_defs.svh"
`timescale 1ns/1ns
`default_nettype none
module mcsc_top #(
	parameter int F_IH_KHZ = `MCSC_F_IH_KHZ,
	parameter int F_MX_KHZ = `MCSC_F_MX_KHZ
) (
	// clock and reset
	input wire logic CLK,
	input wire logic RST,
	// avalon-mm slave
	input wire logic AVS_READ,
	input wire logic AVS_WRITE,
	input wire logic [3:0] AVS_ADDRESS,
	input wire logic [3:0] AVS_BYTEENABLE,
	input wire logic [31:0] AVS_WRITEDATA,
	output logic [31:0] AVS_READDATA,
	output logic AVS_WAITREQUEST,
	// oscillator clock pins
	input wire logic IH_CLK_PIN,
	input wire logic MX_CLK_PIN,
	// clock tree control
	output logic CPU_SRC,
	output logic PERIPH_SRC,
	output logic IH_OSC_EN,
	output logic MX_OSC_EN,
	output logic CRYSTAL_MODE,
	output logic EXT_INPUT_MODE
);
	localparam int LIM_TO_MX = (F_MX_KHZ >= F_IH_KHZ) ? `MCSC_MIN_SWITCH_CYCLES :
		(`MCSC_MIN_SWITCH_CYCLES * F_IH_KHZ) / F_MX_KHZ;
	localparam int LIM_TO_IH = (F_IH_KHZ >= F_MX_KHZ) ? `MCSC_MIN_SWITCH_CYCLES :
		(`MCSC_MIN_SWITCH_CYCLES * F_MX_KHZ) / F_IH_KHZ;
	localparam logic [15:0] LIMIT_MX = 16'(LIM_TO_MX);
	localparam logic [15:0] LIMIT_IH = 16'(LIM_TO_IH);

	mcsc_pkg::mcsc_req_t req;
	mcsc_pkg::mcsc_osc_t osc;
	logic mode_crystal;
	logic mode_ext;
	logic halt_ih;
	logic halt_mx;
	mcsc_pkg::mcsc_state_t state;
	logic select;
	logic status;
	logic mode_written;
	logic ack;
	logic [15:0] count;
	logic [15:0] limit;
	logic [1:0] pin_in;
	logic [1:0] tick;
	logic old_tick;
	logic take;
	logic wr_ctrl;
	logic wr_osc;
	logic wr_mode;

	////////////////////////////////////////////////////////////////////////////////////////////
	// pin synchronisers
	assign pin_in = {MX_CLK_PIN, IH_CLK_PIN};

	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_sync
			mcsc_sync u_sync (
				.clk(CLK),
				.rst(RST),
				.d(pin_in[gi]),
				.rise(tick[gi])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////////////////////
	// bus slave: one wait cycle, then the access completes
	assign req = '{read: AVS_READ, write: AVS_WRITE, address: AVS_ADDRESS,
		byteenable: AVS_BYTEENABLE, writedata: AVS_WRITEDATA};
	assign AVS_WAITREQUEST = (req.read | req.write) & ~ack;
	// a write lands at the edge where waitrequest is low, as the master sees it
	assign take = req.write & ack;
	assign wr_ctrl = take & (req.address == `MCSC_OFS_SYSCLK_CTRL) & req.byteenable[0];
	assign wr_osc = take & (req.address == `MCSC_OFS_OSC_RUN) & req.byteenable[0];
	assign wr_mode = take & (req.address == `MCSC_OFS_OP_MODE)
		& (req.byteenable == `MCSC_BYTE_ACCESS) & ~mode_written;

	always_ff @(posedge CLK) begin
		if (RST) begin
			ack <= 1'b0;
		end else begin
			ack <= (req.read | req.write) & ~ack;
		end
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			AVS_READDATA <= 32'h0;
		end else if (req.read & ~ack) begin
			AVS_READDATA <= 32'h0;
			case (req.address)
				`MCSC_OFS_SYSCLK_CTRL: begin
					AVS_READDATA[`MCSC_BIT_SELECT] <= select;
					AVS_READDATA[`MCSC_BIT_STATUS] <= status;
				end
				`MCSC_OFS_OSC_RUN: begin
					AVS_READDATA[`MCSC_BIT_IH_HALT] <= osc.ih_halt;
					AVS_READDATA[`MCSC_BIT_MX_HALT] <= osc.mx_halt;
				end
				`MCSC_OFS_OP_MODE: begin
					AVS_READDATA[`MCSC_BIT_CRYSTAL] <= osc.crystal;
					AVS_READDATA[`MCSC_BIT_EXT_IN] <= osc.ext_in;
				end
				default: begin
					AVS_READDATA <= 32'h0;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////////////////
	// registers
	always_ff @(posedge CLK) begin
		if (RST) begin
			select <= 1'b0;
		end else if (wr_ctrl) begin
			select <= req.writedata[`MCSC_BIT_SELECT];
		end
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			mode_written <= 1'b0;
			mode_crystal <= 1'b0;
			mode_ext <= 1'b0;
		end else if (wr_mode) begin
			mode_written <= 1'b1;
			mode_crystal <= req.writedata[`MCSC_BIT_CRYSTAL];
			mode_ext <= req.writedata[`MCSC_BIT_EXT_IN];
		end
	end

	// a halt request against the running source is dropped; clearing is always allowed
	always_ff @(posedge CLK) begin
		if (RST) begin
			halt_ih <= `MCSC_RST_IH_HALT;
			halt_mx <= `MCSC_RST_MX_HALT;
		end else if (wr_osc) begin
			halt_ih <= req.writedata[`MCSC_BIT_IH_HALT] & status
				& (state == mcsc_pkg::MCSC_RUN);
			halt_mx <= req.writedata[`MCSC_BIT_MX_HALT] & ~status
				& (state == mcsc_pkg::MCSC_RUN);
		end
	end

	////////////////////////////////////////////////////////////////////////////////////////////
	// switchover sequencer
	assign old_tick = status ? tick[1] : tick[0];
	assign limit = status ? LIMIT_IH : LIMIT_MX;

	always_ff @(posedge CLK) begin
		if (RST) begin
			state <= mcsc_pkg::MCSC_RUN;
			status <= 1'b0;
			count <= 16'h0;
		end else begin
			case (state)
				mcsc_pkg::MCSC_RUN: begin
					count <= 16'h0;
					if (select != status) begin
						state <= mcsc_pkg::MCSC_WAIT;
					end
				end
				mcsc_pkg::MCSC_WAIT: begin
					if (select == status) begin
						state <= mcsc_pkg::MCSC_RUN;
						count <= 16'h0;
					end else if (old_tick) begin
						if (count + 16'h1 >= limit) begin
							status <= select;
							state <= mcsc_pkg::MCSC_RUN;
							count <= 16'h0;
						end else begin
							count <= count + 16'h1;
						end
					end
				end
				default: begin
					state <= mcsc_pkg::MCSC_RUN;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////////////////
	// clock tree control
	assign CPU_SRC = status;
	assign PERIPH_SRC = status;
	// one driver per bit: the struct is only assembled here
	assign osc = '{crystal: mode_crystal, ext_in: mode_ext, ih_halt: halt_ih,
		mx_halt: halt_mx};
	assign IH_OSC_EN = ~osc.ih_halt;
	assign MX_OSC_EN = ~osc.mx_halt;
	assign CRYSTAL_MODE = osc.crystal;
	assign EXT_INPUT_MODE = osc.ext_in;
endmodule // mcsc_top
`default_nettype wire

// ==== testbench/mcsc_asserts.sv ====
// Purpose: port checks of mcsc_top
// Assumes: bound to every mcsc_top
// Notes: idle counters show how recently each source pin moved
`timescale 1ns/1ns
`default_nettype none
module mcsc_asserts (
	// clock and reset
	input wire logic CLK,
	input wire logic RST,
	// bus
	input wire logic AVS_READ,
	input wire logic AVS_WRITE,
	input wire logic AVS_WAITREQUEST,
	// pins and clock tree
	input wire logic IH_CLK_PIN,
	input wire logic MX_CLK_PIN,
	input wire logic CPU_SRC,
	input wire logic PERIPH_SRC,
	input wire logic IH_OSC_EN,
	input wire logic MX_OSC_EN,
	input wire logic CRYSTAL_MODE,
	input wire logic EXT_INPUT_MODE
);
	default clocking @(posedge CLK); endclocking
	default disable iff (RST);
	logic [3:0] ih_idle;
	logic [3:0] mx_idle;
	logic mode_seen;
	wire req = AVS_READ | AVS_WRITE;
	always_ff @(posedge CLK) begin
		ih_idle <= (RST || $changed(IH_CLK_PIN)) ? 4'h0 : ih_idle + {3'h0, ih_idle != 4'hF};
		mx_idle <= (RST || $changed(MX_CLK_PIN)) ? 4'h0 : mx_idle + {3'h0, mx_idle != 4'hF};
		mode_seen <= RST ? 1'b0 : mode_seen | (!$past(RST) && $changed({CRYSTAL_MODE, EXT_INPUT_MODE}));
	end
	periph_follow_a: assert property (PERIPH_SRC == CPU_SRC)
		else $error("peripheral source differs from cpu source");
	one_wait_a: assert property (req && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
		else $error("waitrequest held beyond one cycle");
	wait_start_a: assert property (req && !$past(req) |-> AVS_WAITREQUEST)
		else $error("new request answered without a wait cycle");
	reset_vals_a: assert property ($past(RST) |-> !CPU_SRC && IH_OSC_EN && !MX_OSC_EN && !CRYSTAL_MODE && !EXT_INPUT_MODE)
		else $error("clock tree outputs not at reset values");
	mx_halt_guard_a: assert property ($fell(MX_OSC_EN) |-> !CPU_SRC)
		else $error("system clock halted while in use");
	ih_halt_guard_a: assert property ($fell(IH_OSC_EN) |-> CPU_SRC)
		else $error("internal oscillator halted while in use");
	to_mx_paced_a: assert property ($rose(CPU_SRC) |-> ih_idle < 4'hC)
		else $error("switch to system clock without old source edges");
	to_ih_paced_a: assert property ($fell(CPU_SRC) && !$past(RST) |-> mx_idle < 4'hC)
		else $error("switch to internal oscillator without old source edges");
	mode_once_a: assert property (mode_seen |-> $stable({CRYSTAL_MODE, EXT_INPUT_MODE}))
		else $error("operation mode changed twice");
endmodule // mcsc_asserts
bind mcsc_top mcsc_asserts u_chk (.CLK, .RST, .AVS_READ, .AVS_WRITE, .AVS_WAITREQUEST,
	.IH_CLK_PIN, .MX_CLK_PIN, .CPU_SRC, .PERIPH_SRC, .IH_OSC_EN, .MX_OSC_EN,
	.CRYSTAL_MODE, .EXT_INPUT_MODE);
`default_nettype wire

// ==== testbench/tb.sv ====
// Purpose: self-checking bench of mcsc_top
// Assumes: source pins toggle every two or three cycles
// Notes: model bits track the register contents
`timescale 1ns/1ns
`default_nettype none
module tb;
	logic CLK = 0;
	logic RST = 1;
	logic IH_CLK_PIN = 0;
	logic MX_CLK_PIN = 0;
	logic mx_run = 1;
	logic [31:0] AVS_READDATA;
	logic AVS_WAITREQUEST, CPU_SRC, PERIPH_SRC, IH_OSC_EN, MX_OSC_EN, CRYSTAL_MODE, EXT_INPUT_MODE;
	mcsc_pkg::mcsc_req_t req = '0;
	logic [31:0] seed = 32'h36FA503F;
	logic [3:0] cnt = 4'h0;
	logic sel = 0, st = 0, ihh = 0, mxh = 1, mdone = 0;
	logic [1:0] md = 2'h0;
	int errors = 0;
	int total_checks = 0;
	mcsc_top DUT (.CLK, .RST, .AVS_READ(req.read), .AVS_WRITE(req.write), .AVS_ADDRESS(req.address),
		.AVS_BYTEENABLE(req.byteenable), .AVS_WRITEDATA(req.writedata), .AVS_READDATA,
		.AVS_WAITREQUEST, .IH_CLK_PIN, .MX_CLK_PIN, .CPU_SRC, .PERIPH_SRC, .IH_OSC_EN,
		.MX_OSC_EN, .CRYSTAL_MODE, .EXT_INPUT_MODE);
	always #10 CLK = !CLK;
	always @(posedge CLK) begin
		cnt <= (cnt == 4'h5) ? 4'h0 : cnt + 4'h1;
		if (cnt == 4'h0 || cnt == 4'h3) IH_CLK_PIN <= !IH_CLK_PIN;
		if (mx_run && cnt[0]) MX_CLK_PIN <= !MX_CLK_PIN;
	end
	////////////////////////////////////////////////////////////////
	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		total_checks++;
		if (s !== e) begin
			errors++;
			$display("wrong value %s expected %h seen %h", nm, e, s);
		end
	endtask
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic logic [31:0] model(input logic [3:0] a);
		case (a)
			4'h0: return {26'h0, st, sel, 4'h0};
			4'h4: return {24'h0, mxh, 6'h0, ihh};
			4'h8: return {24'h0, md, 6'h0};
			default: return 32'h0;
		endcase
	endfunction
	// hold the request until waitrequest is seen low at a rising edge
	task automatic bus(input logic w, input logic [3:0] a, input logic [3:0] be,
		input logic [31:0] d, output logic [31:0] q);
		int n;
		n = 0;
		req <= {!w, w, a, be, d};
		do @(posedge CLK); while (AVS_WAITREQUEST !== 1'b0 && ++n < 50);
		q = AVS_READDATA;
		req <= '0;
		@(posedge CLK);
		chk("wait", n < 50, 32'h1);
	endtask
	task automatic rd(input logic [3:0] a);
		logic [31:0] q;
		bus(1'b0, a, 4'hF, 32'h0, q);
		chk("read", q, model(a));
	endtask
	task automatic wr(input logic [3:0] a, input logic [3:0] be, input logic [7:0] d);
		logic [31:0] q;
		seed = lfsr(seed);
		bus(1'b1, a, be, {seed[31:8], d}, q);
		if (be[0] && a == 4'h0) sel = d[4];
		if (be[0] && a == 4'h4) ihh = d[0] & st;
		if (be[0] && a == 4'h4) mxh = d[7] & !st;
		if (be == 4'h1 && a == 4'h8 && !mdone) md = d[7:6];
		if (be == 4'h1 && a == 4'h8) mdone = 1;
	endtask
	task automatic ports(input logic [5:0] e);
		@(negedge CLK);
		chk("ports", {CPU_SRC, PERIPH_SRC, IH_OSC_EN, MX_OSC_EN, CRYSTAL_MODE, EXT_INPUT_MODE}, e);
		@(posedge CLK);
	endtask
	// poll the status bit until the switch lands
	task automatic poll();
		int n;
		logic [31:0] q;
		n = 0;
		do bus(1'b0, 4'h0, 4'hF, 32'h0, q); while (q[5] !== sel && ++n < 40);
		st = sel;
		chk("status", q, model(4'h0));
	endtask
	task automatic tally_and_finish();
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	initial begin
		#100000;
		errors++;
		tally_and_finish();
	end
	initial begin
		repeat (3) @(posedge CLK);
		RST <= 1'b0;
		ports(6'h08);
		for (int a = 0; a < 16; a += 4) rd(4'(a));
		wr(4'h4, 4'h1, 8'h01);
		rd(4'h4);
		wr(4'h8, 4'hF, 8'hC0);
		wr(4'h8, 4'h1, 8'h40);
		wr(4'h8, 4'h1, 8'hC0);
		rd(4'h8);
		wr(4'hC, 4'hF, 8'hFF);
		rd(4'hC);
		wr(4'h0, 4'h1, 8'h30);
		ports(6'h0E);
		poll();
		wr(4'h4, 4'h1, 8'h81);
		rd(4'h4);
		ports(6'h36);
		wr(4'h4, 4'h1, 8'h00);
		mx_run <= 1'b0;
		wr(4'h0, 4'h1, 8'h00);
		repeat (30) @(posedge CLK);
		ports(6'h3E);
		mx_run <= 1'b1;
		poll();
		wr(4'h4, 4'h1, 8'h80);
		rd(4'h4);
		ports(6'h0A);
		// second reset: the operation mode accepts one write again
		RST <= 1'b1;
		repeat (3) @(posedge CLK);
		RST <= 1'b0;
		{sel, st, ihh, mxh, mdone, md} = 7'h08;
		ports(6'h08);
		wr(4'h8, 4'h1, 8'hC0);
		rd(4'h8);
		ports(6'h0B);
		tally_and_finish();
	end
endmodule // tb
`default_nettype wire
